/* File: design/uehr_top.sv */
// Host-visible register emulation of a FIFO serial port, with processor-side access
// Function
// (RQ1) Overwrite option set: receive write during overrun replaces last FIFO entry, else ignored.
// (RQ2) Identification bits 7:6 read FIFO mode, bits 5:4 read zero.
// (RQ3) Identification code reports highest source: line, trigger, timeout, transmit, modem.
// (RQ4) Sources clear by status read, occupancy drop, FIFO read, or register writes.
// (RQ5) Bit 0 low while pending; contents frozen during the host identification read.
// (RQ6) Line status bit 7 shows any FIFO byte error, only in FIFO mode.
// (RQ7) Processor writes transmitter-empty; double-buffer mode sets it when both buffers empty.
// (RQ8) Holding-empty flag: host copy timer-delayed, processor copy not; host write clears.
// (RQ9) Halt with access-interrupt feature forces host holding-empty flag to zero.
// (RQ10) Processor error writes go to shadows, copied and cleared on next receive write.
// (RQ11) FIFO head error flags accumulate across reads and clear on status read.
// (RQ12) Overrun sets on write into full buffer, no transfer, cleared by status read.
// (RQ13) Data ready immediate or timer delayed; processor copy immediate; cleared when empty.
// (RQ14) Enable bits 7:4 read zero; enable bit 3 with modem deltas interrupts.
// (RQ15) Enable bit 2 with line status bits 1 to 4 interrupts.
// (RQ16) Enable bit 1 with holding-empty interrupts.
// (RQ17) Enable bit 0 with data ready or receive timeout interrupts.
// (RQ18) Line control bit 7 maps offsets 0 and 1 onto the divisor bytes.
// (RQ19) Loop mode feeds modem outputs back to status inputs; control bits 7:5 read zero.
// (RQ20) Master selection 10 lets out 2 control the host interrupt pin.
// (RQ21) Processor writes modem status bits 7:4; host only reads them.
// (RQ22) Deltas set on carrier, ready, clear-to-send change and ring fall; cleared on read.
// (RQ23) Host FIFO control bit 0 selects FIFO mode; other bits only with it set.
// (RQ24) Trigger field selects 1, 4, 8 or 14 bytes.
// (RQ25) All state in flip-flops on one clock; reset clears everything. The code resets identification to 01, not zero.
module uehr_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Host register port
  input wire uehr_pkg::uehr_hreq_t HOST_REQ,
  output logic [7:0] HOST_RDATA,
  output logic HOST_INTR,
  // Processor register port
  input wire uehr_pkg::uehr_mreq_t MPU_REQ,
  output logic [7:0] MPU_RDATA,
  // Processor status and controls
  input wire logic HALT,
  input wire logic ACCESS_INT_FEAT,
  input wire logic [1:0] MASTER_SEL,
  input wire logic DOUBLE_BUF,
  input wire logic TSR_EMPTY,
  // Receive FIFO and timer
  input wire logic [4:0] RX_COUNT,
  input wire logic RX_FULL,
  input wire logic RX_ERR_ANY,
  input wire logic [2:0] RX_HEAD_ERR,
  input wire logic [7:0] RX_HEAD_DATA,
  input wire logic RX_TIMEOUT,
  input wire logic RX_TIMER_EN,
  input wire logic RX_TIMER_DONE,
  output uehr_pkg::uehr_rxpush_t RX_PUSH,
  output logic RX_POP,
  // Transmit FIFO and timer
  input wire logic TX_FIFO_EMPTY,
  input wire logic TX_TIMER_EN,
  input wire logic TX_TIMER_DONE,
  output logic TX_PUSH,
  output logic [7:0] TX_DATA,
  output logic FIFO_MODE
);
  import uehr_pkg::*;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  uehr_state_t q, d;

  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = TRIG_LVL0;
      2'h1: trig_level = TRIG_LVL1;
      2'h2: trig_level = TRIG_LVL2;
      default: trig_level = TRIG_LVL3;
    endcase
  endfunction

  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] b);
    hit = strobe && (a == b);
  endfunction

  logic div_sel;
  logic h_data_rd, h_data_wr, h_ier_rd, h_iir_rd, h_fcr_wr, h_lsr_rd, h_msr_rd;
  logic m_rx_wr, m_thr_rd, m_lsr_wr;
  logic rx_blocked, rx_accept, rx_ovw;
  logic line_src, rx_src, to_src, transmit_holding_empty_src, msr_src;
  logic [3:0] msr_eff;
  logic [3:0] delta_set;
  logic transmit_holding_empty_vis;
  logic [7:0] iir_now;
  logic [7:0] lsr_host;

  assign div_sel = q.line_control[LCR_DIV_SEL_BIT];
  assign h_data_rd = hit(HOST_REQ.rd, {5'h00, HOST_REQ.addr}, {5'h00, HOFS_DATA}) && !div_sel;
  assign h_data_wr = hit(HOST_REQ.wr, {5'h00, HOST_REQ.addr}, {5'h00, HOFS_DATA}) && !div_sel;
  assign h_ier_rd = hit(HOST_REQ.rd, {5'h00, HOST_REQ.addr}, {5'h00, HOFS_IER}) && !div_sel;
  assign h_iir_rd = hit(HOST_REQ.rd, {5'h00, HOST_REQ.addr}, {5'h00, HOFS_IIR});
  assign h_fcr_wr = hit(HOST_REQ.wr, {5'h00, HOST_REQ.addr}, {5'h00, HOFS_IIR});
  assign h_lsr_rd = hit(HOST_REQ.rd, {5'h00, HOST_REQ.addr}, {5'h00, HOFS_LSR});
  assign h_msr_rd = hit(HOST_REQ.rd, {5'h00, HOST_REQ.addr}, {5'h00, HOFS_MSR});
  assign m_rx_wr = hit(MPU_REQ.wr, MPU_REQ.addr, MOFS_DATA);
  assign m_thr_rd = hit(MPU_REQ.rd, MPU_REQ.addr, MOFS_DATA);
  assign m_lsr_wr = hit(MPU_REQ.wr, MPU_REQ.addr, MOFS_LSR);

  // A write into a full buffer is an overrun; the option only lets it replace the last entry
  assign rx_blocked = q.fifo_en ? RX_FULL : q.dr_mpu;
  assign rx_accept = m_rx_wr && !rx_blocked;
  assign rx_ovw = m_rx_wr && rx_blocked && q.ovw; // RQ1

  // Loop mode: carrier from out 2, ring from out 1, ready from terminal ready, cts from rts
  assign msr_eff = q.modem_control[MCR_LOOP_BIT] ? {q.modem_control[3], q.modem_control[2], q.modem_control[0], q.modem_control[1]} : q.msr_hi; // RQ19
  assign delta_set = {msr_eff[3] ^ q.msr_prev[3], q.msr_prev[2] & ~msr_eff[2],
                      msr_eff[1:0] ^ q.msr_prev[1:0]}; // RQ22

  // Host sees holding-empty forced low while the core sleeps with access interrupts on
  assign transmit_holding_empty_vis = q.transmit_holding_empty_host && !(HALT && ACCESS_INT_FEAT); // RQ9

  assign line_src = q.host_interrupt_enable[2] && (q.oe || (|q.err)); // RQ15
  assign rx_src = q.host_interrupt_enable[0] && q.dr_host &&
                  (!q.fifo_en || (RX_COUNT >= trig_level(q.trig))); // RQ17 RQ24
  assign to_src = q.host_interrupt_enable[0] && q.to_pend; // RQ17
  assign transmit_holding_empty_src = q.host_interrupt_enable[1] && q.transmit_holding_empty_int; // RQ16
  assign msr_src = q.host_interrupt_enable[3] && (|q.delta); // RQ14

  always_comb begin
    iir_now = {{2{q.fifo_en}}, 2'h0, IID_MODEM, 1'b1}; // RQ2
    if (line_src) begin
      iir_now[3:1] = IID_LINE; // RQ3
    end else if (rx_src) begin
      iir_now[3:1] = IID_RXTRIG;
    end else if (to_src) begin
      iir_now[3:1] = IID_TIMEOUT;
    end else if (transmit_holding_empty_src) begin
      iir_now[3:1] = IID_TRANSMIT_HOLDING_EMPTY;
    end
    iir_now[0] = !(line_src || rx_src || to_src || transmit_holding_empty_src || msr_src); // RQ5
  end

  assign lsr_host = {q.fifo_en && RX_ERR_ANY, q.temt, transmit_holding_empty_vis, q.err, q.oe, q.dr_host}; // RQ6

  always_comb begin
    d = q;
    d.rxp = '0;
    d.tx_push = 1'b0;
    // Frozen while the host reads it, so the code read matches the pin
    d.interrupt_identification = h_iir_rd ? q.interrupt_identification : iir_now; // RQ5
    d.intr = (MASTER_SEL == MASTER_OUT2_SEL) ? q.modem_control[MCR_OUT2_BIT] : !q.interrupt_identification[0]; // RQ20
    d.msr_prev = msr_eff;

    // Host writes
    if (HOST_REQ.wr) begin
      case (HOST_REQ.addr)
        HOFS_DATA: begin
          if (div_sel) begin
            d.dll = HOST_REQ.wdata; // RQ18
          end else begin
            d.transmit_holding = HOST_REQ.wdata;
            d.tx_push = 1'b1;
          end
        end
        HOFS_IER: begin
          if (div_sel) begin
            d.dlm = HOST_REQ.wdata; // RQ18
          end else begin
            d.host_interrupt_enable = HOST_REQ.wdata[3:0]; // RQ14
          end
        end
        HOFS_IIR: begin
          d.fifo_en = HOST_REQ.wdata[FCR_EN_BIT]; // RQ23
          if (HOST_REQ.wdata[FCR_EN_BIT]) begin
            d.trig = HOST_REQ.wdata[7:6]; // RQ24
          end
          // A mode change clears data ready and a pending timeout, not the buffered bytes
          if (HOST_REQ.wdata[FCR_EN_BIT] != q.fifo_en) begin
            d.dr_host = 1'b0;
            d.dr_mpu = 1'b0;
            d.dr_wait = 1'b0;
            d.to_pend = 1'b0;
          end
        end
        HOFS_LCR: d.line_control = HOST_REQ.wdata;
        HOFS_MCR: d.modem_control = HOST_REQ.wdata[4:0]; // RQ19
        default: begin
        end
      endcase
    end

    // Processor writes
    if (MPU_REQ.wr) begin
      case (MPU_REQ.addr)
        MOFS_FCR_MOD: d.ovw = MPU_REQ.wdata[MOD_OVW_BIT]; // RQ1
        MOFS_LSR: begin
          d.shadow = MPU_REQ.wdata[4:2]; // RQ10
          d.temt = MPU_REQ.wdata[LSR_TEMT_BIT]; // RQ7
        end
        MOFS_MSR: d.msr_hi = MPU_REQ.wdata[7:4]; // RQ21
        default: begin
        end
      endcase
    end

    // Holding-empty: host copy waits for the timer, processor copy does not
    if (q.fifo_en) begin
      d.transmit_holding_empty_mpu = TX_FIFO_EMPTY; // RQ8
      if (!TX_FIFO_EMPTY) begin
        d.transmit_holding_empty_host = 1'b0;
        d.transmit_holding_empty_wait = 1'b0;
      end else if (!q.transmit_holding_empty_host && !q.transmit_holding_empty_wait) begin
        d.transmit_holding_empty_wait = 1'b1;
      end
    end else if (m_thr_rd) begin
      d.transmit_holding_empty_mpu = 1'b1; // RQ8
      d.transmit_holding_empty_wait = 1'b1;
    end
    if (d.transmit_holding_empty_wait && (!TX_TIMER_EN || TX_TIMER_DONE)) begin
      d.transmit_holding_empty_host = 1'b1; // RQ8
      d.transmit_holding_empty_wait = 1'b0;
    end
    if (h_data_wr) begin
      d.transmit_holding_empty_host = 1'b0; // RQ8
      d.transmit_holding_empty_mpu = 1'b0;
      d.transmit_holding_empty_wait = 1'b0;
    end
    if (DOUBLE_BUF && d.transmit_holding_empty_mpu && TSR_EMPTY) begin
      d.temt = 1'b1; // RQ7
    end

    // Holding-empty interrupt arms on a rising host flag, cleared by either write
    if (h_data_wr || h_fcr_wr) begin
      d.transmit_holding_empty_int = 1'b0; // RQ4
    end
    if (d.transmit_holding_empty_host && !q.transmit_holding_empty_host) begin
      d.transmit_holding_empty_int = 1'b1;
    end

    // Receive side
    if (h_data_rd) begin
      if (!q.fifo_en || RX_COUNT <= 5'h01) begin
        d.dr_host = 1'b0; // RQ13
        d.dr_mpu = 1'b0;
        d.dr_wait = 1'b0;
      end
      d.to_pend = 1'b0; // RQ4
    end
    if (RX_TIMEOUT && q.fifo_en) begin
      d.to_pend = 1'b1;
    end
    if (rx_accept || rx_ovw) begin
      if (q.fifo_en) begin
        d.rxp.push = 1'b1; // RQ1
        d.rxp.overwrite = rx_ovw;
        d.rxp.data = MPU_REQ.wdata;
        d.rxp.err = q.shadow; // RQ10
      end else begin
        d.receive_buffer = MPU_REQ.wdata;
        d.err = q.err | q.shadow; // RQ10
      end
      d.shadow = 3'h0;
    end
    if (rx_accept) begin
      d.dr_mpu = 1'b1; // RQ13
      d.dr_wait = 1'b1;
    end
    if (d.dr_wait && (!RX_TIMER_EN || RX_TIMER_DONE)) begin
      d.dr_host = 1'b1; // RQ13
      d.dr_wait = 1'b0;
    end

    // Status clears on host reads; a same-cycle overrun, head error or delta still sets
    if (h_lsr_rd) begin
      d.oe = 1'b0; // RQ12
      d.err = 3'h0; // RQ11
    end
    // Head flags are taken once, as the byte reaches the head, so a status read really clears
    d.head_new = (RX_POP && RX_COUNT > 5'h01) ||
                 (q.rxp.push && (RX_COUNT == 5'h00 || (q.rxp.overwrite && RX_COUNT == 5'h01)));
    if (q.fifo_en && q.head_new) begin
      d.err = d.err | RX_HEAD_ERR; // RQ11
    end
    if (m_rx_wr && rx_blocked) begin
      d.oe = 1'b1; // RQ12
    end
    if (h_msr_rd) begin
      d.delta = 4'h0; // RQ22
    end
    d.delta = d.delta | delta_set; // RQ22

    // Read data, registered one cycle after the strobe
    d.hrdata = 8'h00;
    if (HOST_REQ.rd) begin
      case (HOST_REQ.addr)
        HOFS_DATA: d.hrdata = div_sel ? q.dll : (q.fifo_en ? RX_HEAD_DATA : q.receive_buffer); // RQ18
        HOFS_IER: d.hrdata = div_sel ? q.dlm : {4'h0, q.host_interrupt_enable}; // RQ14
        HOFS_IIR: d.hrdata = q.interrupt_identification;
        HOFS_LCR: d.hrdata = q.line_control;
        HOFS_MCR: d.hrdata = {3'h0, q.modem_control}; // RQ19
        HOFS_LSR: d.hrdata = lsr_host;
        HOFS_MSR: d.hrdata = {msr_eff, q.delta};
        default: d.hrdata = 8'h00;
      endcase
    end
    d.mrdata = 8'h00;
    if (MPU_REQ.rd) begin
      case (MPU_REQ.addr)
        MOFS_FCR_MOD: d.mrdata = {q.trig, 5'h00, q.fifo_en};
        MOFS_DATA: d.mrdata = q.transmit_holding;
        MOFS_IER: d.mrdata = {4'h0, q.host_interrupt_enable};
        MOFS_LCR: d.mrdata = q.line_control;
        MOFS_MCR: d.mrdata = {3'h0, q.modem_control};
        MOFS_LSR: d.mrdata = {lsr_host[7:6], q.transmit_holding_empty_mpu, q.err, q.oe, q.dr_mpu};
        MOFS_MSR: d.mrdata = {msr_eff, q.delta};
        MOFS_DLL: d.mrdata = q.dll;
        MOFS_DLM: d.mrdata = q.dlm;
        default: d.mrdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      q <= UEH_STATE_RST; // RQ25
    end else begin
      q <= d;
    end
  end

  assign HOST_RDATA = q.hrdata;
  assign MPU_RDATA = q.mrdata;
  assign HOST_INTR = q.intr;
  assign RX_PUSH = q.rxp;
  assign RX_POP = h_data_rd && q.fifo_en;
  assign TX_PUSH = q.tx_push;
  assign TX_DATA = q.transmit_holding;
  assign FIFO_MODE = q.fifo_en;

  ovw_ignore_a: assert property (m_rx_wr && q.fifo_en && RX_FULL && !q.ovw |=> !RX_PUSH.push) // RQ1
    else $error("write into full FIFO was not ignored");
  iir_fixed_a: assert property (!h_iir_rd ##1 1 |-> q.interrupt_identification[5:4] == 2'h0 && // RQ2
                                q.interrupt_identification[7:6] == {2{$past(q.fifo_en)}})
    else $error("identification fixed bits wrong");
  line_prio_a: assert property (line_src && !h_iir_rd |=> q.interrupt_identification[3:1] == IID_LINE) // RQ3
    else $error("line source not reported first");
  iir_freeze_a: assert property (h_iir_rd |=> q.interrupt_identification == $past(q.interrupt_identification)) // RQ5
    else $error("identification changed during host read");
  oe_clear_a: assert property (h_lsr_rd && !m_rx_wr |=> !q.oe) // RQ12
    else $error("overrun not cleared by status read");
  dr_fast_a: assert property (rx_accept && !RX_TIMER_EN |=> q.dr_host && q.dr_mpu) // RQ13
    else $error("data ready not immediate");
  transmit_holding_empty_clr_a: assert property (h_data_wr |=> !q.transmit_holding_empty_host && !q.transmit_holding_empty_mpu) // RQ8
    else $error("holding-empty not cleared by host write");
  transmit_holding_empty_halt_a: assert property (h_lsr_rd && HALT && ACCESS_INT_FEAT |=> !HOST_RDATA[5]) // RQ9
    else $error("holding-empty visible during halt");
  cts_delta_a: assert property (msr_eff[0] != q.msr_prev[0] |=> q.delta[0]) // RQ22
    else $error("clear-to-send change missed");
  ier_top_a: assert property (h_ier_rd |=> HOST_RDATA[7:4] == 4'h0) // RQ14
    else $error("enable upper bits not zero");
  loop_map_a: assert property (q.modem_control[MCR_LOOP_BIT] |-> msr_eff[3] == q.modem_control[3] && // RQ19
                               msr_eff[1] == q.modem_control[0])
    else $error("loop mapping wrong");

  overrun_c: cover property (m_rx_wr && rx_blocked);
  freeze_c: cover property (h_iir_rd && iir_now != q.interrupt_identification);
  fifo_push_c: cover property (RX_PUSH.push && RX_PUSH.err != 3'h0);
  loop_c: cover property (q.modem_control[MCR_LOOP_BIT] && delta_set != 4'h0);
endmodule

/* File: design/uehr_pkg.sv */
// Package for the serial-port emulation register block: offsets, fields, codes, carriers
package uehr_pkg;
  // Host side offsets (three address lines)
  localparam logic [2:0] HOFS_DATA = 3'h0;
  localparam logic [2:0] HOFS_IER = 3'h1;
  localparam logic [2:0] HOFS_IIR = 3'h2;
  localparam logic [2:0] HOFS_LCR = 3'h3;
  localparam logic [2:0] HOFS_MCR = 3'h4;
  localparam logic [2:0] HOFS_LSR = 3'h5;
  localparam logic [2:0] HOFS_MSR = 3'h6;
  // Processor side offsets (low address byte)
  localparam logic [7:0] MOFS_FCR_MOD = 8'he9;
  localparam logic [7:0] MOFS_DATA = 8'hf0;
  localparam logic [7:0] MOFS_IER = 8'hf1;
  localparam logic [7:0] MOFS_LCR = 8'hf3;
  localparam logic [7:0] MOFS_MCR = 8'hf4;
  localparam logic [7:0] MOFS_LSR = 8'hf5;
  localparam logic [7:0] MOFS_MSR = 8'hf6;
  localparam logic [7:0] MOFS_DLL = 8'hf8;
  localparam logic [7:0] MOFS_DLM = 8'hf9;
  // Field positions
  localparam int LCR_DIV_SEL_BIT = 7;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_OUT2_BIT = 3;
  localparam int FCR_EN_BIT = 0;
  localparam int MOD_OVW_BIT = 1;
  localparam int LSR_TEMT_BIT = 6;
  // Interrupt identification codes
  localparam logic [2:0] IID_LINE = 3'h3;
  localparam logic [2:0] IID_RXTRIG = 3'h2;
  localparam logic [2:0] IID_TIMEOUT = 3'h6;
  localparam logic [2:0] IID_TRANSMIT_HOLDING_EMPTY = 3'h1;
  localparam logic [2:0] IID_MODEM = 3'h0;
  // Receive trigger levels in bytes
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0e;
  // Master control selection that routes out 2 onto the host interrupt pin
  localparam logic [1:0] MASTER_OUT2_SEL = 2'h2;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uehr_hreq_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } uehr_mreq_t;

  typedef struct packed {
    logic push;
    logic overwrite;
    logic [7:0] data;
    logic [2:0] err;
  } uehr_rxpush_t;

  typedef struct packed {
    logic [3:0] host_interrupt_enable;
    logic [7:0] line_control;
    logic [4:0] modem_control;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic fifo_en;
    logic [1:0] trig;
    logic ovw;
    logic [7:0] receive_buffer;
    logic [7:0] transmit_holding;
    logic dr_host;
    logic dr_mpu;
    logic dr_wait;
    logic oe;
    logic [2:0] err;
    logic [2:0] shadow;
    logic temt;
    logic transmit_holding_empty_host;
    logic transmit_holding_empty_mpu;
    logic transmit_holding_empty_wait;
    logic transmit_holding_empty_int;
    logic to_pend;
    logic [3:0] msr_hi;
    logic [3:0] msr_prev;
    logic [3:0] delta;
    logic [7:0] interrupt_identification;
    logic intr;
    logic [7:0] hrdata;
    logic [7:0] mrdata;
    uehr_rxpush_t rxp;
    logic head_new;
    logic tx_push;
  } uehr_state_t;

  // Identification idles at "no interrupt pending" so the host pin stays low out of reset
  localparam uehr_state_t UEH_STATE_RST = '{interrupt_identification: 8'h01, default: '0};
endpackage

/* File: verif/uehr_rxfifo_model.sv */
// Behavioural receive FIFO standing behind the register block
module uehr_rxfifo_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block side
  input wire uehr_pkg::uehr_rxpush_t push,
  input wire logic pop,
  // FIFO status
  output logic [4:0] count,
  output logic full,
  output logic err_any,
  output logic [2:0] head_err,
  output logic [7:0] head_data
);
  import uehr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] q[$];
  logic e;
  // Status is registered from the queue at each edge; no process waits on the queue itself
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q.delete();
      count <= 5'h00;
      full <= 1'b0;
      err_any <= 1'b0;
      head_err <= 3'h0;
      head_data <= 8'ha5;
    end else begin
      if (pop && q.size() > 0) begin
        void'(q.pop_front());
      end
      if (push.push) begin
        if (push.overwrite && q.size() > 0) begin
          q[q.size() - 1] = {push.err, push.data};
        end else if (q.size() < 16) begin
          q.push_back({push.err, push.data});
        end
      end
      e = 1'b0;
      foreach (q[i]) begin
        e = e | (|q[i][10:8]);
      end
      count <= 5'(q.size());
      full <= (q.size() == 16);
      err_any <= e;
      // Empty FIFO shows a pattern rather than stale data
      head_err <= (q.size() > 0) ? q[0][10:8] : 3'h0;
      head_data <= (q.size() > 0) ? q[0][7:0] : 8'ha5;
    end
  end
endmodule

/* File: verif/uehr_top_tb.sv */
// Self-checking bench for the serial-port emulation register block
module uehr_top_tb;
  import uehr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, halt = 0, feat = 0, dbuf = 0, tsr_e = 0, rx_tmo = 0;
  logic rx_ten = 0, rx_tdone = 0, tx_fe = 1, tx_ten = 0, tx_tdone = 0;
  logic [1:0] msel = 2'h0;
  uehr_hreq_t hq = '0;
  uehr_mreq_t mq = '0;
  uehr_rxpush_t rxp;
  logic [7:0] hrd, mrd, txd;
  logic intr, pop, txp, fmode, rfull, rerr;
  logic [4:0] rcnt;
  logic [2:0] herr;
  logic [7:0] hdat;
  int bad_count = 0, compares = 0, cyc = 0;
  uehr_top dut (.CLOCK(clk), .RST(rst), .HOST_REQ(hq), .HOST_RDATA(hrd), .HOST_INTR(intr),
    .MPU_REQ(mq), .MPU_RDATA(mrd), .HALT(halt), .ACCESS_INT_FEAT(feat), .MASTER_SEL(msel),
    .DOUBLE_BUF(dbuf), .TSR_EMPTY(tsr_e), .RX_COUNT(rcnt), .RX_FULL(rfull),
    .RX_ERR_ANY(rerr), .RX_HEAD_ERR(herr), .RX_HEAD_DATA(hdat), .RX_TIMEOUT(rx_tmo),
    .RX_TIMER_EN(rx_ten), .RX_TIMER_DONE(rx_tdone), .RX_PUSH(rxp), .RX_POP(pop),
    .TX_FIFO_EMPTY(tx_fe), .TX_TIMER_EN(tx_ten), .TX_TIMER_DONE(tx_tdone), .TX_PUSH(txp),
    .TX_DATA(txd), .FIFO_MODE(fmode));
  uehr_rxfifo_model fifo (.clk(clk), .rst(rst), .push(rxp), .pop(pop), .count(rcnt),
    .full(rfull), .err_any(rerr), .head_err(herr), .head_data(hdat));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic hwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 hq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    #1 hq = '0;
  endtask
  task automatic hchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    #1 hq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 hq = '0;
    chk($sformatf("host offset %0d", a), hrd & m, e);
  endtask
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 mq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    #1 mq = '0;
  endtask
  task automatic mchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    #1 mq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1 mq = '0;
    chk($sformatf("processor offset %h", a), mrd & m, e);
  endtask
  task automatic t_regs();
    hchk(HOFS_IIR, 8'hff, 8'h01);
    hchk(HOFS_LSR, 8'hff, 8'h00);
    hwr(HOFS_IER, 8'hff);
    hchk(HOFS_IER, 8'hff, 8'h0f);
    hwr(HOFS_LCR, 8'h80);
    hwr(HOFS_DATA, 8'h5a);
    hwr(HOFS_IER, 8'ha5);
    hchk(HOFS_DATA, 8'hff, 8'h5a);
    mchk(MOFS_DLM, 8'hff, 8'ha5);
    hwr(HOFS_LCR, 8'h03);
    hchk(HOFS_IER, 8'hff, 8'h0f);
    mchk(MOFS_LCR, 8'hff, 8'h03);
    hwr(HOFS_IER, 8'h00);
  endtask
  task automatic t_modem();
    mwr(MOFS_MSR, 8'h80);
    hwr(HOFS_IER, 8'h08);
    idle(3);
    hchk(HOFS_IIR, 8'hff, 8'h00);
    chk("intr", {7'h0, intr}, 8'h01);
    hchk(HOFS_MSR, 8'hff, 8'h88);
    hwr(HOFS_IER, 8'h00);
    hwr(HOFS_MCR, 8'hff);
    idle(2);
    hchk(HOFS_MCR, 8'hff, 8'h1f);
    hchk(HOFS_MSR, 8'hff, 8'hf3);
    hwr(HOFS_MCR, 8'h10);
    idle(2);
    hchk(HOFS_MSR, 8'hff, 8'h0f);
    hchk(HOFS_MSR, 8'hff, 8'h00);
    msel = 2'h2;
    hwr(HOFS_MCR, 8'h08);
    idle(3);
    chk("intr out2", {7'h0, intr}, 8'h01);
    hwr(HOFS_MCR, 8'h00);
    idle(3);
    chk("intr out2", {7'h0, intr}, 8'h00);
    msel = 2'h0;
  endtask
  task automatic t_rx();
    hwr(HOFS_IER, 8'h04);
    mwr(MOFS_LSR, 8'h1c);
    mwr(MOFS_DATA, 8'h3c);
    idle(3);
    hchk(HOFS_IIR, 8'hff, 8'h06);
    hchk(HOFS_LSR, 8'hff, 8'h1d);
    hchk(HOFS_LSR, 8'hff, 8'h01);
    hchk(HOFS_DATA, 8'hff, 8'h3c);
    hchk(HOFS_LSR, 8'hff, 8'h00);
    mwr(MOFS_DATA, 8'h11);
    mwr(MOFS_DATA, 8'h22);
    idle(2);
    hchk(HOFS_LSR, 8'hff, 8'h03);
    hchk(HOFS_DATA, 8'hff, 8'h11);
    mwr(MOFS_FCR_MOD, 8'h02);
    mwr(MOFS_DATA, 8'h33);
    mwr(MOFS_DATA, 8'h44);
    idle(2);
    hchk(HOFS_DATA, 8'hff, 8'h44);
    mwr(MOFS_FCR_MOD, 8'h00);
    hchk(HOFS_LSR, 8'hff, 8'h02);
    rx_ten = 1;
    mwr(MOFS_DATA, 8'h55);
    idle(2);
    hchk(HOFS_LSR, 8'h01, 8'h00);
    mchk(MOFS_LSR, 8'h01, 8'h01);
    rx_tdone = 1;
    idle(1);
    rx_tdone = 0;
    idle(2);
    hchk(HOFS_LSR, 8'h01, 8'h01);
    hchk(HOFS_DATA, 8'hff, 8'h55);
    rx_ten = 0;
  endtask
  task automatic t_tx();
    hwr(HOFS_IER, 8'h02);
    hwr(HOFS_DATA, 8'h5a);
    chk("tx push", {7'h0, txp}, 8'h01);
    chk("tx data", txd, 8'h5a);
    mchk(MOFS_DATA, 8'hff, 8'h5a);
    idle(3);
    hchk(HOFS_LSR, 8'h20, 8'h20);
    hchk(HOFS_IIR, 8'hff, 8'h02);
    halt = 1;
    feat = 1;
    idle(2);
    hchk(HOFS_LSR, 8'h20, 8'h00);
    halt = 0;
    idle(2);
    hchk(HOFS_LSR, 8'h20, 8'h20);
    hwr(HOFS_IIR, 8'h00);
    idle(3);
    hchk(HOFS_IIR, 8'hff, 8'h01);
    feat = 0;
  endtask
  task automatic t_fifo();
    hwr(HOFS_IIR, 8'h01);
    idle(2);
    chk("fifo mode", {7'h0, fmode}, 8'h01);
    hwr(HOFS_IER, 8'h01);
    mwr(MOFS_LSR, 8'h04);
    mwr(MOFS_DATA, 8'ha1);
    mwr(MOFS_DATA, 8'hb2);
    idle(4);
    hchk(HOFS_IIR, 8'hff, 8'hc4);
    hchk(HOFS_LSR, 8'h9f, 8'h85);
    hchk(HOFS_DATA, 8'hff, 8'ha1);
    idle(3);
    hchk(HOFS_LSR, 8'h9f, 8'h01);
    hchk(HOFS_DATA, 8'hff, 8'hb2);
    idle(3);
    hchk(HOFS_LSR, 8'h9f, 8'h00);
    mwr(MOFS_LSR, 8'h40);
    hchk(HOFS_LSR, 8'h40, 8'h40);
    mwr(MOFS_LSR, 8'h00);
    hchk(HOFS_LSR, 8'h40, 8'h00);
    dbuf = 1;
    tsr_e = 1;
    idle(2);
    hchk(HOFS_LSR, 8'h40, 8'h40);
    dbuf = 0;
    rx_tmo = 1;
    idle(1);
    rx_tmo = 0;
    idle(2);
    hchk(HOFS_IIR, 8'hff, 8'hcc);
    hchk(HOFS_DATA, 8'hff, 8'ha5);
    hchk(HOFS_IIR, 8'hff, 8'hc1);
  endtask
  task automatic end_of_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000) begin
        bad_count++;
        end_of_test();
      end
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    t_regs();
    t_modem();
    t_rx();
    t_tx();
    t_fifo();
    end_of_test();
  end
endmodule
